// >>> tb/apb_host.sv
`timescale 1ns/100ps
// ====
// host: one transfer at a time, held until pready
module apb_host
(
	input wire i_clk,
	input wire i_pready,
	output reg o_psel = 1'b0,
	output reg o_penable = 1'b0,
	output reg o_pwrite = 1'b0,
	output reg [11:0] o_paddr = 12'h000,
	output reg [31:0] o_pwdata = 32'h0
);
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
	begin
		@(posedge i_clk);
		o_psel <= 1'b1;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		@(posedge i_clk);
		o_penable <= 1'b1;
		@(posedge i_clk);
		while (!i_pready)
			@(posedge i_clk);
		o_psel <= 1'b0;
		o_penable <= 1'b0;
	end
	endtask
endmodule

// >>> tb/dma_event_props.sv
`timescale 1ns/100ps
// ====
// port checks
module dma_event_props
(
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire o_pready,
	input wire [31:0] o_prdata,
	input wire o_pslverr,
	input wire i_rx_crc_error,
	input wire i_local_bus_config_mode,
	input wire o_pci_interrupt_out_n,
	input wire o_local_bus_interrupt_out_n,
	input wire o_ram_standby
);
	reg [15:0] mask_q;
	wire acc = i_psel & i_penable;
	wire bad = i_paddr != 12'h028 && i_paddr != 12'h02C && i_paddr != 12'h050 && i_paddr != 12'h080;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// shadow of the mask, so pin checks know which events may reach it
	always @(posedge i_clk_sys or negedge i_rst_n)
		if (!i_rst_n)
			mask_q <= 16'h0000;
		else if (acc && i_pwrite && i_paddr == 12'h02C)
			mask_q <= i_pwdata[15:0] & 16'hFFFC;
	sequence crc_unmasked;
		i_rx_crc_error && mask_q[2] && !(acc && i_pwrite);
	endsequence
	AST_PREADY: assert property (o_pready) else $error("pready low");
	AST_UNMAPPED: assert property (acc && bad |-> o_pslverr && (i_pwrite || o_prdata == 32'h0))
		else $error("unmapped access not refused");
	AST_UPPER: assert property (acc && !i_pwrite |-> o_prdata[31:16] == 16'h0000) else $error("upper read bits set");
	AST_STANDBY: assert property (acc && i_pwrite && i_paddr == 12'h050 |=> o_ram_standby == $past(i_pwdata[0]))
		else $error("standby not from write");
	AST_CRC_IRQ: assert property (crc_unmasked |=> ##1 !o_pci_interrupt_out_n)
		else $error("unmasked event gave no interrupt");
	AST_MASKED: assert property ($past(mask_q) == 16'h0000 |-> o_pci_interrupt_out_n)
		else $error("interrupt while all masked");
	AST_LOCAL_OFF: assert property (!$past(i_local_bus_config_mode) |-> o_local_bus_interrupt_out_n)
		else $error("local interrupt outside config mode");
	AST_LOCAL_ON: assert property ($past(i_local_bus_config_mode) |-> o_local_bus_interrupt_out_n == o_pci_interrupt_out_n)
		else $error("local interrupt differs from pci");
endmodule
bind dma_event_status_and_mask dma_event_props u_props (.*);

// >>> tb/dma_event_status_and_mask_tb.sv
`timescale 1ns/100ps
module dma_event_status_and_mask_tb;
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_ram_standby;
	logic o_pci_interrupt_out_n, o_local_bus_interrupt_out_n;
	logic [11:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, r;
	logic [14:0] o_internal_test;
	logic [15:0] ev = 16'h0000;
	logic i_local_bus_config_mode = 1'b1;
	logic [31:0] exp_q[$];
	int fail_count = 0, num_checks = 0, cycles = 0;
	dma_event_status_and_mask dut (.*, .i_rx_crc_error(ev[2]), .i_rx_abort_seen(ev[3]),
		.i_rx_length_violation(ev[4]), .i_rx_fifo_overflow(ev[5]), .i_large_free_queue_read(ev[6]),
		.i_large_free_queue_empty_error(ev[7]), .i_small_free_queue_read(ev[8]),
		.i_small_free_queue_empty_error(ev[9]), .i_rx_done_queue_write(ev[10]),
		.i_rx_done_queue_full_error(ev[11]), .i_tx_fifo_underflow(ev[12]), .i_tx_pending_queue_read(ev[13]),
		.i_tx_done_queue_write(ev[14]), .i_tx_done_queue_full_error(ev[15]));
	apb_host u_host (.i_clk(i_clk_sys), .i_pready(o_pready), .o_psel(i_psel), .o_penable(i_penable),
		.o_pwrite(i_pwrite), .o_paddr(i_paddr), .o_pwdata(i_pwdata));
	initial
		forever #2.5 i_clk_sys = ~i_clk_sys;
	task check(input logic [31:0] s, input logic [31:0] e);
	begin
		num_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	end
	endtask
	task results;
	begin
		$display("checks=%0d errors=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
	begin
		exp_q.push_back(e);
		u_host.xfer(1'b0, a, 32'h0);
	end
	endtask
	task pulse(input logic [15:0] b);
	begin
		@(posedge i_clk_sys);
		ev <= b;
		@(posedge i_clk_sys);
		ev <= 16'h0000;
	end
	endtask
	task irq(input logic p, input logic l);
	begin
		@(posedge i_clk_sys);
		#1 check({31'h0, o_pci_interrupt_out_n}, {31'h0, p});
		check({31'h0, o_local_bus_interrupt_out_n}, {31'h0, l});
	end
	endtask
	// ====
	// read data is matched against the oldest note at the access edge
	always @(posedge i_clk_sys)
		if (i_psel && i_penable && o_pready && !i_pwrite)
			check(o_prdata, exp_q.pop_front());
	always @(posedge i_clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fail_count++;
			results;
		end
	end
	initial
	begin
		void'($urandom(68616));
		repeat (4) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		rd(12'h02C, 32'h0);
		rd(12'h050, 32'h0);
		rd(12'h040, 32'h0);
		r = $urandom;
		u_host.xfer(1'b1, 12'h02C, r);
		rd(12'h02C, r & 32'hFFFC);
		u_host.xfer(1'b1, 12'h050, 32'h1);
		#1 check({17'h0, o_internal_test, o_ram_standby}, 32'h1);
		u_host.xfer(1'b1, 12'h050, 32'h0);
		#1 check({17'h0, o_internal_test, o_ram_standby}, 32'h0);
		u_host.xfer(1'b1, 12'h02C, 32'hFFFF);
		for (int i = 2; i < 16; i++)
		begin
			if (i == 10 || i == 14)
				continue;
			@(posedge i_clk_sys);
			i_local_bus_config_mode <= i[0];
			pulse(16'h1 << i);
			irq(1'b0, ~i[0]);
			rd(12'h028, 32'h1 << i);
			rd(12'h028, 32'h0);
			irq(1'b1, 1'b1);
		end
		// both thresholds share one code so one pulse feeds both counters
		for (int n = 0; n < 8; n++)
		begin
			u_host.xfer(1'b1, 12'h080, 32'(n * 17));
			repeat ((1 << n) - 1) pulse(16'h4400);
			rd(12'h028, 32'h0);
			pulse(16'h4400);
			rd(12'h028, 32'h4400);
		end
		fork
			rd(12'h028, 32'h0);
			begin
				repeat (2) @(posedge i_clk_sys);
				ev <= 16'h8000;
				@(posedge i_clk_sys);
				ev <= 16'h0000;
			end
		join
		rd(12'h028, 32'h8000);
		results;
	end
endmodule

// >>> verilog/dma_event_map.vh
`ifndef DMA_EVENT_MAP_VH
`define DMA_EVENT_MAP_VH
// ==========================================
// register byte offsets
`define OFS_DMA_EVENT_STATUS 12'h028
`define OFS_DMA_EVENT_INTERRUPT_MASK 12'h02C
`define OFS_FACTORY_TEST_CONTROL 12'h050
`define OFS_DONE_THRESHOLD_CONTROL 12'h080
// ==========================================
// reset values
`define RST_DMA_EVENT_INTERRUPT_MASK 16'h0000
`define RST_FACTORY_TEST_CONTROL 16'h0000
`define RST_DONE_THRESHOLD_CONTROL 16'h0000
// ==========================================
// status and mask bit positions
`define BIT_RX_CRC_ERROR 2
`define BIT_RX_ABORT_SEEN 3
`define BIT_RX_LENGTH_VIOLATION 4
`define BIT_RX_FIFO_OVERFLOW 5
`define BIT_LARGE_FREE_QUEUE_READ 6
`define BIT_LARGE_FREE_QUEUE_EMPTY_ERROR 7
`define BIT_SMALL_FREE_QUEUE_READ 8
`define BIT_SMALL_FREE_QUEUE_EMPTY_ERROR 9
`define BIT_RX_DONE_QUEUE_WRITTEN 10
`define BIT_RX_DONE_QUEUE_FULL_ERROR 11
`define BIT_TX_FIFO_UNDERFLOW 12
`define BIT_TX_PENDING_QUEUE_READ 13
`define BIT_TX_DONE_QUEUE_WRITTEN 14
`define BIT_TX_DONE_QUEUE_FULL_ERROR 15
`define EVENT_BITS_MASK 16'hFFFC
// ==========================================
// threshold control fields and factory test bit
`define FLD_RX_DONE_THRESHOLD_LSB 0
`define FLD_TX_DONE_THRESHOLD_LSB 4
`define BIT_FACTORY_TEST 0
`endif

// >>> verilog/dma_event_status_and_mask.v
// Function
// - rx done-write flag sets per write or after 2..128 writes by threshold.
// - status read clears rx done-write flag until the next write.
// - rx done-queue full write attempt sets error flag; read clears.
// - any tx fifo underflow sets flag; read clears.
// - each tx pending-queue read sets flag; read clears.
// - tx done-write flag sets per write or after 2..128 writes by threshold.
// - status read clears tx done-write flag until the next write.
// - tx done-queue full write attempt sets error flag; read clears.
// - set flag with mask bit 1 drives active-low pci interrupt.
// - unmasked event also drives local-bus interrupt in configuration mode only.
// - mask bits 2..15, 0 masks, 1 unmasks, reset to 0.
// - factory test bit 0 puts rams in standby; software writes 0.
// - status bits 2..5 flag rx crc, abort, length, overflow; clear on read.
// - status bits 6..9 flag free-queue reads and empty errors; clear on read.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`include "dma_event_map.vh"
module dma_event_status_and_mask
(
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output wire o_pready,
	output reg [31:0] o_prdata,
	output wire o_pslverr,
	input wire i_rx_crc_error,
	input wire i_rx_abort_seen,
	input wire i_rx_length_violation,
	input wire i_rx_fifo_overflow,
	input wire i_large_free_queue_read,
	input wire i_large_free_queue_empty_error,
	input wire i_small_free_queue_read,
	input wire i_small_free_queue_empty_error,
	input wire i_rx_done_queue_write,
	input wire i_rx_done_queue_full_error,
	input wire i_tx_fifo_underflow,
	input wire i_tx_pending_queue_read,
	input wire i_tx_done_queue_write,
	input wire i_tx_done_queue_full_error,
	input wire i_local_bus_config_mode,
	output reg o_pci_interrupt_out_n,
	output reg o_local_bus_interrupt_out_n,
	output wire o_ram_standby,
	output wire [14:0] o_internal_test
);
	// ==========================================
	// registers and internal nets
	reg [15:0] mask_q;
	reg [15:0] mask_d;
	reg [15:0] test_q;
	reg [15:0] test_d;
	reg [15:0] thresh_q;
	reg [15:0] thresh_d;

	// event and pin side
	reg [15:0] set_vec;
	reg [31:0] prdata_d;
	reg pci_irq_n_d;
	reg local_irq_n_d;
	reg mapped;
	wire [15:0] flags;
	wire [2:0] rx_code;
	wire [2:0] tx_code;

	// bus side
	wire access;
	wire wr;
	wire rd_setup;
	wire rd_status;
	wire sel_status;
	wire sel_mask;
	wire sel_test;
	wire sel_thresh;
	wire wr_mask;
	wire wr_test;
	wire wr_thresh;
	wire rx_hit;
	wire tx_hit;
	wire irq_pending;

	// ==========================================
	// helper functions
	// registers are word aligned; the two byte-lane bits take no part in the match
	function is_addr;
		input [11:0] a;
		input [11:0] b;
		begin
			is_addr = (a[11:2] == b[11:2]);
		end
	endfunction

	// every register is 16 bits wide and reads back in the low half of the word
	function [31:0] low_half;
		input [15:0] v;
		begin
			low_half = {16'h0000, v};
		end
	endfunction

	// a flag reaches the pins only through a mask bit of one
	function any_unmasked;
		input [15:0] f;
		input [15:0] m;
		begin
			any_unmasked = |(f & m);
		end
	endfunction

	// ==========================================
	// bus decode
	// pready is tied high: every access completes in its first access cycle
	assign o_pready = 1'b1;
	assign access = i_psel && i_penable;
	assign wr = access && i_pwrite;
	assign rd_setup = i_psel && !i_penable && !i_pwrite;
	assign sel_status = is_addr(i_paddr, `OFS_DMA_EVENT_STATUS);
	assign sel_mask = is_addr(i_paddr, `OFS_DMA_EVENT_INTERRUPT_MASK);
	assign sel_test = is_addr(i_paddr, `OFS_FACTORY_TEST_CONTROL);
	assign sel_thresh = is_addr(i_paddr, `OFS_DONE_THRESHOLD_CONTROL);
	assign wr_mask = wr && sel_mask;
	assign wr_test = wr && sel_test;
	assign wr_thresh = wr && sel_thresh;
	// the clear lands at the access edge, one edge after the read word was captured
	assign rd_status = access && !i_pwrite && sel_status;
	// unmapped offsets answer with an error, read zero and ignore writes
	assign o_pslverr = access && !mapped;

	always @*
	begin
		if (sel_status)
			mapped = 1'b1;
		else if (sel_mask)
			mapped = 1'b1;
		else if (sel_test)
			mapped = 1'b1;
		else if (sel_thresh)
			mapped = 1'b1;
		else
			mapped = 1'b0;
	end

	// ==========================================
	// writable registers
	// bits 1:0 have no event behind them and stay zero
	always @*
	begin
		mask_d = mask_q;
		if (wr_mask)
			mask_d = i_pwdata[15:0] & `EVENT_BITS_MASK;
	end

	// test bit 0 idles the rams; the others are raw internal controls
	always @*
	begin
		test_d = test_q;
		if (wr_test)
			test_d = i_pwdata[15:0];
	end

	// only the two three-bit codes are kept; the rest of the word reads zero
	always @*
	begin
		thresh_d = thresh_q;
		if (wr_thresh)
			thresh_d = {9'h000, i_pwdata[6:4], 1'b0, i_pwdata[2:0]};
	end

	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			mask_q <= `RST_DMA_EVENT_INTERRUPT_MASK;
			test_q <= `RST_FACTORY_TEST_CONTROL;
			thresh_q <= `RST_DONE_THRESHOLD_CONTROL;
		end
		else
		begin
			mask_q <= mask_d;
			test_q <= test_d;
			thresh_q <= thresh_d;
		end
	end

	// ==========================================
	// test controls
	// bits go out as written; software keeps 1..15 at zero, nothing here guards them
	assign o_ram_standby = test_q[`BIT_FACTORY_TEST];
	assign o_internal_test = test_q[15:1];

	// ==========================================
	// done-queue write counters
	assign rx_code = thresh_q[`FLD_RX_DONE_THRESHOLD_LSB+2:`FLD_RX_DONE_THRESHOLD_LSB];
	assign tx_code = thresh_q[`FLD_TX_DONE_THRESHOLD_LSB+2:`FLD_TX_DONE_THRESHOLD_LSB];

	// code 0 sets the flag on every write, code n after 2^n writes
	// a new code acts on the running count; change it only between bursts
	done_write_counter rx_done_count
	(
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_threshold(rx_code),
		.i_write(i_rx_done_queue_write),
		.o_hit(rx_hit)
	);

	done_write_counter tx_done_count
	(
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_threshold(tx_code),
		.i_write(i_tx_done_queue_write),
		.o_hit(tx_hit)
	);

	// ==========================================
	// event collection
	always @*
	begin
		set_vec = 16'h0000;
		set_vec[`BIT_RX_CRC_ERROR] = i_rx_crc_error;
		set_vec[`BIT_RX_ABORT_SEEN] = i_rx_abort_seen;
		set_vec[`BIT_RX_LENGTH_VIOLATION] = i_rx_length_violation;
		set_vec[`BIT_RX_FIFO_OVERFLOW] = i_rx_fifo_overflow;
		set_vec[`BIT_LARGE_FREE_QUEUE_READ] = i_large_free_queue_read;
		set_vec[`BIT_LARGE_FREE_QUEUE_EMPTY_ERROR] = i_large_free_queue_empty_error;
		set_vec[`BIT_SMALL_FREE_QUEUE_READ] = i_small_free_queue_read;
		set_vec[`BIT_SMALL_FREE_QUEUE_EMPTY_ERROR] = i_small_free_queue_empty_error;
		set_vec[`BIT_RX_DONE_QUEUE_WRITTEN] = rx_hit;
		set_vec[`BIT_RX_DONE_QUEUE_FULL_ERROR] = i_rx_done_queue_full_error;
		set_vec[`BIT_TX_FIFO_UNDERFLOW] = i_tx_fifo_underflow;
		set_vec[`BIT_TX_PENDING_QUEUE_READ] = i_tx_pending_queue_read;
		set_vec[`BIT_TX_DONE_QUEUE_WRITTEN] = tx_hit;
		set_vec[`BIT_TX_DONE_QUEUE_FULL_ERROR] = i_tx_done_queue_full_error;
	end

	// bits 1:0 never set, so they read zero for good
	event_flag_bank flags_bank
	(
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_set(set_vec),
		.i_clear(rd_status),
		.o_flags(flags)
	);

	// ==========================================
	// interrupt outputs
	// the pins are registered so they never glitch while flags and mask settle
	assign irq_pending = any_unmasked(flags, mask_q);

	always @*
	begin
		pci_irq_n_d = 1'b1;
		local_irq_n_d = 1'b1;
		if (irq_pending)
		begin
			pci_irq_n_d = 1'b0;
			if (i_local_bus_config_mode)
				local_irq_n_d = 1'b0;
		end
	end

	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_pci_interrupt_out_n <= 1'b1;
			o_local_bus_interrupt_out_n <= 1'b1;
		end
		else
		begin
			o_pci_interrupt_out_n <= pci_irq_n_d;
			o_local_bus_interrupt_out_n <= local_irq_n_d;
		end
	end

	// ==========================================
	// read data
	// the word is taken in the setup cycle so it stands through the access cycle;
	// an event in the setup cycle shows now, one in the access cycle waits for the next read
	always @*
	begin
		if (sel_status)
			prdata_d = low_half(flags | set_vec);
		else if (sel_mask)
			prdata_d = low_half(mask_q);
		else if (sel_test)
			prdata_d = low_half(test_q);
		else if (sel_thresh)
			prdata_d = low_half(thresh_q);
		else
			prdata_d = 32'h00000000;
	end

	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_prdata <= 32'h00000000;
		else if (rd_setup)
			o_prdata <= prdata_d;
	end
endmodule

// >>> verilog/done_write_counter.v
`timescale 1ns/100ps
// ==========================================
// counts done-queue writes; pulses when the programmed count is reached
// threshold code 0 = every write, code n = 2^n writes (2..128)
module done_write_counter
(
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire [2:0] i_threshold,
	input wire i_write,
	output wire o_hit
);
	reg [7:0] count_q;
	reg [7:0] count_d;
	wire [7:0] limit;

	assign limit = (8'h01 << i_threshold);
	assign o_hit = i_write && ((count_q + 8'h01) >= limit);

	always @*
	begin
		count_d = count_q;
		if (i_write)
		begin
			if (o_hit)
				count_d = 8'h00;
			else
				count_d = count_q + 8'h01;
		end
	end

	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			count_q <= 8'h00;
		else
			count_q <= count_d;
	end
endmodule

// >>> verilog/event_flag_bank.v
`timescale 1ns/100ps
// ==========================================
// sticky clear-on-read flags; a set in the clearing cycle wins
module event_flag_bank
(
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire [15:0] i_set,
	input wire i_clear,
	output reg [15:0] o_flags
);
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_flags <= 16'h0000;
		else if (i_clear)
			o_flags <= i_set;
		else
			o_flags <= o_flags | i_set;
	end
endmodule
